// >>> design/flash_guard_pkg.sv
// Constants and types for the self-programming guard.
// Assumes a single CPU clock domain and a synchronous active-high reset.
package flash_guard_pkg;
  localparam logic [1:0] PROT_NONE     = 2'h3;
  localparam logic [1:0] PROT_NO_WRITE = 2'h2;
  localparam logic [1:0] PROT_ALL      = 2'h0;
  localparam logic [1:0] PROT_NO_READ  = 2'h1;
  localparam logic [1:0] LOCK_ERASED   = 2'h3;
  localparam int         APP_RESET_WORD = 0;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_READABLE = 3'h2,
    ST_HALT  = 3'h4
  } prog_state_e;
endpackage

// >>> design/boot_flash_self_program_guard.sv
// Access guard and sequencing for flash self-programming.
// Assumes the core holds requests stable for one cycle and the flash reports done.
`timescale 1ns/100ps
module boot_flash_self_program_guard #(
  parameter int AW        = 14,
  parameter int HALT_REGION_BASE = 8192,
  parameter int BOOT_W0   = 1024,
  parameter int BOOT_W1   = 2048,
  parameter int BOOT_W2   = 4096,
  parameter int BOOT_W3   = 8192
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_reset,
  input  wire logic [1:0]    i_boot_size_fuses,
  input  wire logic          i_reset_vector_select_fuse,
  input  wire logic          i_vectors_in_boot,
  input  wire logic [AW-1:0] i_pc,
  input  wire logic          i_store_req,
  input  wire logic          i_store_is_prog,
  input  wire logic          i_store_is_lock,
  input  wire logic          i_buffer_load,
  input  wire logic [AW-1:0] i_store_addr,
  input  wire logic [1:0]    i_lock_data_app,
  input  wire logic [1:0]    i_lock_data_boot,
  input  wire logic [1:0]    i_lock_data_gen,
  input  wire logic          i_chip_erase,
  input  wire logic          i_prog_done,
  input  wire logic          i_region_read_reenable,
  input  wire logic          i_load_req,
  input  wire logic [AW-1:0] i_load_addr,
  input  wire logic          i_irq_req,
  output logic               o_prog_start,
  output logic               o_store_refused,
  output logic               o_load_allow,
  output logic               o_load_refused,
  output logic               o_cpu_halt,
  output logic               o_region_busy_flag,
  output logic               o_irq_allow,
  output logic [1:0]         o_app_protect_field,
  output logic [1:0]         o_boot_protect_field,
  output logic [1:0]         o_general_lock,
  output logic [AW-1:0]      o_reset_vector
);
  // Refuse sizes that put the boot section outside the halting region
  if (BOOT_W3 > (1 << AW) - HALT_REGION_BASE || HALT_REGION_BASE >= (1 << AW) ||
      BOOT_W0 > BOOT_W1 || BOOT_W1 > BOOT_W2 || BOOT_W2 > BOOT_W3) begin : g_size_check
    $error("Boot section must fit inside halting region");
  end

  localparam logic [AW-1:0] TOP = '1;
  localparam logic [AW-1:0] HALT_B = AW'(HALT_REGION_BASE);

  flash_guard_pkg::prog_state_e state_ff;
  flash_guard_pkg::prog_state_e nxt_state;
  logic [1:0] app_ff;
  logic [1:0] boot_ff;
  logic [1:0] gen_ff;
  logic       busy_ff;
  logic       start_ff;
  logic       sref_ff;
  logic       lok_ff;
  logic       lref_ff;
  logic       halt_ff;
  logic       irq_ff;
  logic [AW-1:0] rv_ff;

  // Boot section start from fuses, always in halting region
  logic [AW-1:0] boot_words;
  assign boot_words = (i_boot_size_fuses == 2'h3) ? AW'(BOOT_W0) :
                      (i_boot_size_fuses == 2'h2) ? AW'(BOOT_W1) :
                      (i_boot_size_fuses == 2'h1) ? AW'(BOOT_W2) : AW'(BOOT_W3);
  wire [AW-1:0] boot_start = TOP - boot_words + AW'(1);

  wire pc_in_boot    = (i_pc >= boot_start);
  wire st_in_boot    = (i_store_addr >= boot_start);
  wire st_in_halt    = (i_store_addr >= HALT_B);
  wire ld_in_boot    = (i_load_addr >= boot_start);
  wire ld_in_halt    = (i_load_addr >= HALT_B);

  // Store gating, general lock not consulted
  wire app_no_wr  = (app_ff == flash_guard_pkg::PROT_NO_WRITE) ||
                    (app_ff == flash_guard_pkg::PROT_ALL);
  wire boot_no_wr = (boot_ff == flash_guard_pkg::PROT_NO_WRITE) ||
                    (boot_ff == flash_guard_pkg::PROT_ALL);
  wire sect_wr_ok = st_in_boot ? !boot_no_wr : !app_no_wr;
  wire idle       = (state_ff == flash_guard_pkg::ST_IDLE);
  wire store_ok   = i_store_req && i_store_is_prog && pc_in_boot && idle && sect_wr_ok;
  wire store_bad  = i_store_req && i_store_is_prog && !(pc_in_boot && idle && sect_wr_ok);
  wire lock_ok    = i_store_req && i_store_is_lock && pc_in_boot && idle;

  // Load gating
  wire app_no_rd  = (app_ff == flash_guard_pkg::PROT_ALL) ||
                    (app_ff == flash_guard_pkg::PROT_NO_READ);
  wire boot_no_rd = (boot_ff == flash_guard_pkg::PROT_ALL) ||
                    (boot_ff == flash_guard_pkg::PROT_NO_READ);
  wire ld_prot    = (pc_in_boot && !ld_in_boot && app_no_rd) ||
                    (!pc_in_boot && ld_in_boot && boot_no_rd);
  wire ld_busy_blk = busy_ff && !ld_in_halt;
  wire load_ok    = i_load_req && !ld_prot && !ld_busy_blk;

  // Interrupt gating
  wire irq_mask = (!pc_in_boot && app_no_rd && i_vectors_in_boot) ||
                  (pc_in_boot && boot_no_rd && !i_vectors_in_boot);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      flash_guard_pkg::ST_IDLE: begin
        if (store_ok) begin
          nxt_state = st_in_halt ? flash_guard_pkg::ST_HALT : flash_guard_pkg::ST_READABLE;
        end
      end
      flash_guard_pkg::ST_READABLE: begin
        if (i_prog_done) begin
          nxt_state = flash_guard_pkg::ST_IDLE;
        end
      end
      flash_guard_pkg::ST_HALT: begin
        if (i_prog_done) begin
          nxt_state = flash_guard_pkg::ST_IDLE;
        end
      end
      default: nxt_state = flash_guard_pkg::ST_IDLE;
    endcase
  end

  // Busy set on readable-region start; set wins over clear
  wire busy_set = store_ok && !st_in_halt;
  wire busy_clr = (idle && i_region_read_reenable) || i_buffer_load;
  wire nxt_busy = busy_set | (busy_ff & ~busy_clr);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_ff <= flash_guard_pkg::ST_IDLE;
      busy_ff  <= 1'b0;
      start_ff <= 1'b0;
      sref_ff  <= 1'b0;
      lok_ff   <= 1'b0;
      lref_ff  <= 1'b0;
      halt_ff  <= 1'b0;
      irq_ff   <= 1'b0;
      rv_ff    <= '0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= nxt_busy;
      start_ff <= store_ok;
      sref_ff  <= store_bad;
      lok_ff   <= load_ok;
      lref_ff  <= i_load_req && !load_ok;
      halt_ff  <= (nxt_state == flash_guard_pkg::ST_HALT);
      irq_ff   <= i_irq_req && !irq_mask;
      rv_ff    <= i_reset_vector_select_fuse ? AW'(flash_guard_pkg::APP_RESET_WORD)
                                             : boot_start;
    end
  end

  // Lock bits: program only (clear bits), restore only on chip erase or reset
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      app_ff  <= flash_guard_pkg::LOCK_ERASED;
      boot_ff <= flash_guard_pkg::LOCK_ERASED;
      gen_ff  <= flash_guard_pkg::LOCK_ERASED;
    end else if (i_chip_erase) begin
      app_ff  <= flash_guard_pkg::LOCK_ERASED;
      boot_ff <= flash_guard_pkg::LOCK_ERASED;
      gen_ff  <= flash_guard_pkg::LOCK_ERASED;
    end else if (lock_ok) begin
      app_ff  <= app_ff & i_lock_data_app;
      boot_ff <= boot_ff & i_lock_data_boot;
      gen_ff  <= gen_ff & i_lock_data_gen;
    end
  end

  assign o_prog_start         = start_ff;
  assign o_store_refused      = sref_ff;
  assign o_load_allow         = lok_ff;
  assign o_load_refused       = lref_ff;
  assign o_cpu_halt           = halt_ff;
  assign o_region_busy_flag   = busy_ff;
  assign o_irq_allow          = irq_ff;
  assign o_app_protect_field  = app_ff;
  assign o_boot_protect_field = boot_ff;
  assign o_general_lock       = gen_ff;
  assign o_reset_vector       = rv_ff;

  a_app_start_blocked: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_store_req && i_store_is_prog && !pc_in_boot) |=> !o_prog_start)
    else $error("Start from application section");
  a_halt_region: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (store_ok && st_in_halt) |=> o_cpu_halt)
    else $error("Halting region store did not stall");
  a_rww_running: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (store_ok && !st_in_halt) |=> !o_cpu_halt && o_region_busy_flag)
    else $error("Readable region store stalled CPU");
  a_busy_holds: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (o_region_busy_flag && !i_region_read_reenable && !i_buffer_load) |=> o_region_busy_flag)
    else $error("Busy flag dropped without clear");
  a_busy_clear: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_buffer_load && !store_ok) |=> !o_region_busy_flag)
    else $error("Buffer load did not clear busy");
  a_app_wr_prot: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_store_req && i_store_is_prog && !st_in_boot && !app_ff[0]) |=> o_store_refused)
    else $error("Application store not refused");
  a_boot_wr_prot: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_store_req && i_store_is_prog && st_in_boot && !boot_ff[0]) |=> !o_prog_start)
    else $error("Boot store not refused");
  a_boot_rd_prot: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_load_req && !pc_in_boot && ld_in_boot && !boot_ff[1]) |=> o_load_refused)
    else $error("Boot load not blocked");
  a_lock_sticky: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (!i_chip_erase && !app_ff[1]) |=> !app_ff[1])
    else $error("Lock bit cleared without erase");

  // Answer pairing
  a_start_refuse_excl: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !(o_prog_start && o_store_refused))
    else $error("Store both started and refused");

  a_store_answer: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_store_req && i_store_is_prog) |=> (o_prog_start || o_store_refused))
    else $error("Store got no answer");

  a_load_excl: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !(o_load_allow && o_load_refused))
    else $error("Load both allowed and refused");

  a_load_answer: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_load_req |=> (o_load_allow || o_load_refused))
    else $error("Load got no answer");

  a_load_quiet: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_load_req |=> (!o_load_allow && !o_load_refused))
    else $error("Load answer without request");

  // Section protection
  a_app_no_limit: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_store_req && i_store_is_prog && pc_in_boot && idle && !st_in_boot &&
     app_ff == flash_guard_pkg::PROT_NONE) |=> o_prog_start)
    else $error("Unprotected application store refused");

  a_boot_no_limit: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_store_req && i_store_is_prog && pc_in_boot && idle && st_in_boot &&
     boot_ff == flash_guard_pkg::PROT_NONE) |=> o_prog_start)
    else $error("Unprotected boot store refused");

  a_gen_lock_ignored: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_store_req && i_store_is_prog && pc_in_boot && idle && sect_wr_ok &&
     gen_ff != flash_guard_pkg::LOCK_ERASED) |=> o_prog_start)
    else $error("General lock blocked a store");

  a_app_rd_prot: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_load_req && pc_in_boot && !ld_in_boot && !app_ff[1]) |=> o_load_refused)
    else $error("Application load not blocked");

  // Region busy and halting
  a_busy_blocks_read: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_load_req && busy_ff && !ld_in_halt) |=> o_load_refused)
    else $error("Busy region was readable");

  a_halt_read_ok: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_load_req && ld_in_halt && !ld_prot) |=> o_load_allow)
    else $error("Halting region read refused");

  a_busy_set: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    busy_set |=> o_region_busy_flag)
    else $error("Busy flag not set");

  a_reenable_clear: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (idle && i_region_read_reenable && !store_ok) |=> !o_region_busy_flag)
    else $error("Re-enable did not clear busy");

  a_halt_holds: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (o_cpu_halt && !i_prog_done) |=> o_cpu_halt)
    else $error("Stall ended early");

  a_halt_release: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (o_cpu_halt && i_prog_done) |=> !o_cpu_halt)
    else $error("Stall did not end");

  a_boot_in_halt: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    boot_start >= HALT_B)
    else $error("Boot section below halting region");

  // Interrupt gating
  a_irq_app_mask: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_irq_req && !pc_in_boot && app_no_rd && i_vectors_in_boot) |=> !o_irq_allow)
    else $error("Interrupt passed in application");

  a_irq_boot_mask: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_irq_req && pc_in_boot && boot_no_rd && !i_vectors_in_boot) |=> !o_irq_allow)
    else $error("Interrupt passed in boot section");

  a_irq_pass: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_irq_req && !irq_mask) |=> o_irq_allow)
    else $error("Unmasked interrupt dropped");

  // Lock fields
  a_erase_restore: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_chip_erase |=> (o_app_protect_field == flash_guard_pkg::LOCK_ERASED &&
                      o_boot_protect_field == flash_guard_pkg::LOCK_ERASED &&
                      o_general_lock == flash_guard_pkg::LOCK_ERASED))
    else $error("Chip erase did not restore locks");

  a_lock_program: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (lock_ok && !i_chip_erase && !i_lock_data_boot[0]) |=> !o_boot_protect_field[0])
    else $error("Lock bit not programmed");

  a_boot_sticky_hi: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (!i_chip_erase && !boot_ff[1]) |=> !boot_ff[1])
    else $error("Boot lock bit cleared without erase");

  a_boot_sticky_lo: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (!i_chip_erase && !boot_ff[0]) |=> !boot_ff[0])
    else $error("Boot lock bit cleared without erase");

  a_gen_sticky: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (!i_chip_erase && !gen_ff[1]) |=> !gen_ff[1])
    else $error("General lock bit cleared without erase");

  // Reset target
  a_reset_vec_app: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_reset_vector_select_fuse |=>
      o_reset_vector == AW'(flash_guard_pkg::APP_RESET_WORD))
    else $error("Reset vector not application start");

  a_reset_vec_boot: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_reset_vector_select_fuse |=> o_reset_vector == $past(boot_start))
    else $error("Reset vector not boot start");
endmodule // boot_flash_self_program_guard

// >>> tb/flash_done_model.sv
// Flash completion side seen by the core: reports each started operation done.
// Assumes o_prog_start from the guard is a one-cycle pulse.
`timescale 1ns/100ps
module flash_done_model #(
  parameter int LAT = 5
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_start,
  output logic      o_done
);
  logic [3:0] cnt_ff;
  // Done only after the whole operation; busy clearing stays with software
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_ff <= 4'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt_ff == 4'h1);
      if (i_start)
        cnt_ff <= LAT[3:0];
      else if (cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule // flash_done_model

// >>> tb/tb_boot_flash_self_program_guard.sv
// Self-checking bench for the self-programming guard.
// Assumes default design parameters and the flash completion model.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_boot_flash_self_program_guard;
  typedef struct packed {
    logic ld; logic ok; logic [1:0] app; logic [1:0] boot; logic [1:0] gen;
    logic [13:0] pc; logic [13:0] ad;
  } row_s;
  localparam logic [13:0] PA = 14'h0100;
  localparam logic [13:0] PB = 14'h3E00;
  localparam logic [13:0] HADR [2] = '{14'h3000, PB};
  localparam row_s ROWS [16] = '{
    '{1'h0, 1'h0, 2'h3, 2'h3, 2'h3, PA, PB},
    '{1'h0, 1'h1, 2'h3, 2'h3, 2'h3, PB, PA},
    '{1'h0, 1'h0, 2'h2, 2'h3, 2'h3, PB, PA},
    '{1'h0, 1'h0, 2'h0, 2'h3, 2'h3, PB, PA},
    '{1'h0, 1'h1, 2'h1, 2'h3, 2'h3, PB, PA},
    '{1'h0, 1'h1, 2'h3, 2'h3, 2'h3, PB, PB},
    '{1'h0, 1'h0, 2'h3, 2'h2, 2'h3, PB, PB},
    '{1'h0, 1'h0, 2'h3, 2'h0, 2'h3, PB, PB},
    '{1'h0, 1'h1, 2'h3, 2'h3, 2'h0, PB, PA},
    '{1'h1, 1'h0, 2'h0, 2'h3, 2'h3, PB, PA},
    '{1'h1, 1'h0, 2'h1, 2'h3, 2'h3, PB, PA},
    '{1'h1, 1'h1, 2'h2, 2'h3, 2'h3, PB, PA},
    '{1'h1, 1'h0, 2'h3, 2'h0, 2'h3, PA, PB},
    '{1'h1, 1'h0, 2'h3, 2'h1, 2'h3, PA, PB},
    '{1'h1, 1'h1, 2'h3, 2'h2, 2'h3, PA, PB},
    '{1'h1, 1'h1, 2'h3, 2'h3, 2'h0, PA, PB}
  };
  logic i_clk_sys, i_reset, i_reset_vector_select_fuse, i_vectors_in_boot, i_store_req;
  logic i_store_is_prog, i_store_is_lock, i_buffer_load, i_chip_erase, i_prog_done;
  logic i_region_read_reenable, i_load_req, i_irq_req;
  logic [1:0] i_boot_size_fuses, i_lock_data_app, i_lock_data_boot, i_lock_data_gen;
  logic [13:0] i_pc, i_store_addr, i_load_addr, o_reset_vector;
  logic o_prog_start, o_store_refused, o_load_allow, o_load_refused, o_cpu_halt;
  logic o_region_busy_flag, o_irq_allow;
  logic [1:0] o_app_protect_field, o_boot_protect_field, o_general_lock;
  int n_errors = 0;
  int checks = 0;
  row_s r;
  boot_flash_self_program_guard i_dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_boot_size_fuses(i_boot_size_fuses),
    .i_reset_vector_select_fuse(i_reset_vector_select_fuse),
    .i_vectors_in_boot(i_vectors_in_boot), .i_pc(i_pc), .i_store_req(i_store_req),
    .i_store_is_prog(i_store_is_prog), .i_store_is_lock(i_store_is_lock),
    .i_buffer_load(i_buffer_load), .i_store_addr(i_store_addr),
    .i_lock_data_app(i_lock_data_app), .i_lock_data_boot(i_lock_data_boot),
    .i_lock_data_gen(i_lock_data_gen), .i_chip_erase(i_chip_erase),
    .i_prog_done(i_prog_done), .i_region_read_reenable(i_region_read_reenable),
    .i_load_req(i_load_req), .i_load_addr(i_load_addr), .i_irq_req(i_irq_req),
    .o_prog_start(o_prog_start), .o_store_refused(o_store_refused),
    .o_load_allow(o_load_allow), .o_load_refused(o_load_refused),
    .o_cpu_halt(o_cpu_halt), .o_region_busy_flag(o_region_busy_flag),
    .o_irq_allow(o_irq_allow), .o_app_protect_field(o_app_protect_field),
    .o_boot_protect_field(o_boot_protect_field), .o_general_lock(o_general_lock),
    .o_reset_vector(o_reset_vector));
  flash_done_model i_model (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_start(o_prog_start), .o_done(i_prog_done));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic tick(input int n = 1);
    repeat (n) begin @(posedge i_clk_sys); #1; end
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic store(input logic [13:0] pc, ad, input logic lk);
    i_pc = pc;
    i_store_addr = ad;
    {i_store_req, i_store_is_prog, i_store_is_lock} = {1'b1, !lk, lk};
    tick();
    {i_store_req, i_store_is_prog, i_store_is_lock} = 3'h0;
  endtask
  task automatic ld(input logic [13:0] ad, input logic ok);
    i_load_addr = ad;
    pulse(i_load_req);
    `CHK("load_allow", ok, o_load_allow)
    `CHK("load_refused", !ok, o_load_refused)
  endtask
  task automatic set_locks(input logic [1:0] a, b, g);
    pulse(i_chip_erase);
    {i_lock_data_app, i_lock_data_boot, i_lock_data_gen} = {a, b, g};
    store(PB, PB, 1'b1);
    tick(8);
    `CHK("fields", {a, b, g}, {o_app_protect_field, o_boot_protect_field, o_general_lock})
  endtask
  task automatic wait_done();
    for (int n = 0; n < 20 && i_prog_done !== 1'b1; n++)
      tick();
    if (i_prog_done !== 1'b1) begin
      n_errors++;
      results();
    end
    tick();
  endtask
  task automatic irq(input logic [13:0] pc, input logic ok);
    i_pc = pc;
    tick(2);
    `CHK("irq_allow", ok, o_irq_allow)
  endtask
  initial begin
    {i_store_req, i_store_is_prog, i_store_is_lock, i_buffer_load, i_chip_erase} = 5'h00;
    {i_region_read_reenable, i_load_req, i_irq_req, i_vectors_in_boot} = 4'h0;
    {i_boot_size_fuses, i_reset_vector_select_fuse, i_pc, i_store_addr, i_load_addr} = '1;
    {i_lock_data_app, i_lock_data_boot, i_lock_data_gen} = 6'h3F;
    i_reset = 1'b1;
    tick(3);
    i_reset = 1'b0;
    `CHK("reset_fields", 6'h3F, {o_app_protect_field, o_boot_protect_field, o_general_lock})
    `CHK("reset_flags", 2'h0, {o_cpu_halt, o_region_busy_flag})
    `CHK("reset_vec0", 14'h0000, o_reset_vector)
    foreach (ROWS[k]) begin
      r = ROWS[k];
      set_locks(r.app, r.boot, r.gen);
      i_pc = r.pc;
      if (r.ld)
        ld(r.ad, r.ok);
      else begin
        store(r.pc, r.ad, 1'b0);
        `CHK("prog_start", r.ok, o_prog_start)
        `CHK("store_refused", !r.ok, o_store_refused)
        if (r.ok) begin
          wait_done();
          pulse(i_region_read_reenable);
        end
      end
    end
    set_locks(2'h3, 2'h3, 2'h3);
    foreach (HADR[k]) begin
      store(PB, HADR[k], 1'b0);
      tick(2);
      `CHK("halt", 2'h2, {o_cpu_halt, o_region_busy_flag})
      wait_done();
      `CHK("halt_end", 1'b0, o_cpu_halt)
    end
    store(PB, PA, 1'b0);
    `CHK("busy_run", 2'h1, {o_cpu_halt, o_region_busy_flag})
    ld(14'h3300, 1'b1);
    ld(PA, 1'b0);
    wait_done();
    tick(2);
    `CHK("busy_kept", 1'b1, o_region_busy_flag)
    pulse(i_region_read_reenable);
    `CHK("busy_reen", 1'b0, o_region_busy_flag)
    store(PB, PA, 1'b0);
    wait_done();
    pulse(i_buffer_load);
    `CHK("busy_bufld", 1'b0, o_region_busy_flag)
    set_locks(2'h0, 2'h3, 2'h3);
    {i_vectors_in_boot, i_irq_req} = 2'h3;
    irq(PA, 1'b0);
    irq(PB, 1'b1);
    set_locks(2'h3, 2'h1, 2'h3);
    i_vectors_in_boot = 1'b0;
    irq(PB, 1'b0);
    irq(PA, 1'b1);
    pulse(i_chip_erase);
    `CHK("erased", 2'h3, o_boot_protect_field)
    {i_boot_size_fuses, i_reset_vector_select_fuse} = 3'h0;
    tick(2);
    `CHK("reset_vec", 14'h2000, o_reset_vector)
    store(14'h2100, PA, 1'b0);
    `CHK("big_boot", 1'b1, o_prog_start)
    wait_done();
    results();
  end
endmodule // tb_boot_flash_self_program_guard
